// >>> shared/lincfg_regs.vh
/*
 * Constants for the two LIN channel configuration registers: SPI frame
 * layout, register addresses, field positions, encodings and reset values.
 * Assumes it is included by bare name from the design files.
 */
`ifndef LINCFG_REGS_VH
`define LINCFG_REGS_VH

// SPI frame layout.
`define LINCFG_FRAME_BITS      5'h1_0
`define LINCFG_CMD_MSB         15
`define LINCFG_CMD_LSB         14
`define LINCFG_ADDR_MSB        13
`define LINCFG_ADDR_LSB        9
`define LINCFG_CMD_WRITE       2'h1
`define LINCFG_ADDR_CH1        5'h1_3
`define LINCFG_ADDR_CH2        5'h1_4
`define LINCFG_DATA_MSB        7
`define LINCFG_DATA_LSB        0

// Field positions inside a channel register.
`define LINCFG_MODE_MSB        7
`define LINCFG_MODE_LSB        6
`define LINCFG_SLEW_MSB        5
`define LINCFG_SLEW_LSB        4
`define LINCFG_TERM_BIT        2
`define LINCFG_LOWSUP_BIT      0

// Mode encodings.
`define LINCFG_MODE_OFF        2'h0
`define LINCFG_MODE_UNUSED     2'h1
`define LINCFG_MODE_WAKE       2'h2
`define LINCFG_MODE_TXRX       2'h3

// Slew classes.
`define LINCFG_SLEW_20K        2'h0
`define LINCFG_SLEW_10K        2'h1

// Writable bits and reset value.
`define LINCFG_WR_MASK         8'hF5
`define LINCFG_RESET           8'h00

// Idle levels of the synchronised pins, sclk in bit 0 up to supply low in bit 6:
// chip select high and both transmit inputs recessive, all others low.
`define LINCFG_SYNC_IDLE       7'h1A

`endif

// >>> src/lincfg_sync.v
/*
 * Two flip-flop synchroniser for a vector of asynchronous levels.
 * Assumes clock_i is the block clock and resetn_i is asynchronous, active low.
 * RESET_VAL gives the idle level of each input, so that the release of reset
 * never shows a level change that did not happen on the pin.
 */
`timescale 1ns/1ps

module lincfg_sync #(
    parameter             WIDTH     = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    // Clock, reset and enable.
    input  wire             clock_i,
    input  wire             resetn_i,
    input  wire             enable_i,
    // Levels.
    input  wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] stage1_q;
    reg [WIDTH-1:0] stage2_q;

    // First stage feeds only the second stage.
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stage1_q <= RESET_VAL;
            stage2_q <= RESET_VAL;
        end else if (enable_i) begin
            stage1_q <= async_i;
            stage2_q <= stage1_q;
        end
    end

    assign sync_o = stage2_q;

endmodule

// >>> src/lincfg_top.v
/*
 * LIN channel configuration registers written over a 16-bit SPI command.
 * The SPI clock is sampled and its edges found on clock_i; chip select,
 * MOSI and both transmit inputs are synchronised first. Assumes SPI mode 0
 * (data sampled on rising sclk), MSB first, chip select active low, and an
 * sclk much slower than clock_i.
 * Assumes sclk and chip select each stay high and low for at least three
 * clock_i cycles, and chip select stays high for at least three cycles
 * between frames.
 * Each synchroniser resets to the idle level of its pin, so no false sclk or
 * chip select edge and no dominant transmit level is seen after reset.
 * A frame commits only when chip select rises after sixteen or more sclk
 * rises; a longer frame keeps its last sixteen bits. The bit between address
 * and data is not checked, and nothing is read back on the serial link.
 * While enable_i is low every flip-flop holds, the synchronisers included,
 * so a frame sent in that time is lost.
 */
`timescale 1ns/1ps
`include "lincfg_regs.vh"

module lincfg_top (
    // Clock, reset, enable.
    input  wire       clock_i,
    input  wire       resetn_i,
    input  wire       enable_i,
    // SPI slave pins.
    input  wire       spi_sclk_i,
    input  wire       spi_csn_i,
    input  wire       spi_mosi_i,
    // Channel transmit inputs, low is dominant.
    input  wire       txd_ch1_i,
    input  wire       txd_ch2_i,
    // Supply and regulator state.
    input  wire       supply_low_i,
    input  wire       transceiver_regulator_on_i,
    // Register contents.
    output reg  [7:0] lin_channel_one_config_o,
    output reg  [7:0] lin_channel_two_config_o,
    // Decoded channel controls.
    output reg  [1:0] txrx_enable_o,
    output reg  [1:0] wake_enable_o,
    output reg  [1:0] fast_slew_o,
    output reg  [1:0] slew_10k_o,
    output reg  [1:0] termination_enable_o,
    output reg  [1:0] force_recessive_o
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisation.

    // Bit positions of the pins inside the synchroniser vector.
    localparam SYNC_SCLK   = 0;
    localparam SYNC_CSN    = 1;
    localparam SYNC_MOSI   = 2;
    localparam SYNC_TXD1   = 3;
    localparam SYNC_TXD2   = 4;
    localparam SYNC_REGON  = 5;
    localparam SYNC_SUPLOW = 6;
    localparam SYNC_WIDTH  = 7;

    wire [SYNC_WIDTH-1:0] pins_w;
    wire [SYNC_WIDTH-1:0] sync_w;

    // Gather the asynchronous pins in the order of the positions above.
    assign pins_w = {supply_low_i, transceiver_regulator_on_i, txd_ch2_i, txd_ch1_i,
                     spi_mosi_i, spi_csn_i, spi_sclk_i};

    // Two flip-flops per pin, reset to the idle levels so that neither an edge
    // nor a dominant transmit level is seen just after reset.
    lincfg_sync #(
        .WIDTH     (SYNC_WIDTH),
        .RESET_VAL (`LINCFG_SYNC_IDLE)
    ) u_sync (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .enable_i (enable_i),
        .async_i  (pins_w),
        .sync_o   (sync_w)
    );

    // Synchronised levels, each read only after its second flip-flop.
    wire       sclk_w   = sync_w[SYNC_SCLK];
    wire       csn_w    = sync_w[SYNC_CSN];
    wire       mosi_w   = sync_w[SYNC_MOSI];
    wire [1:0] txd_w    = {sync_w[SYNC_TXD2], sync_w[SYNC_TXD1]};
    wire       regon_w  = sync_w[SYNC_REGON];
    wire       suplow_w = sync_w[SYNC_SUPLOW];

    ////////////////////////////////////////////////////////////////////////
    // SPI shift register.

    reg        sclk_q;
    reg        csn_q;
    reg [15:0] shift_q;
    reg [4:0]  count_q;

    // Edge detectors on the synchronised levels. Their history flip-flops
    // reset to the idle levels, sclk low and chip select high, so that the
    // release of reset is never taken for an edge.
    wire sclk_rise_w = sclk_w & ~sclk_q;
    wire csn_rise_w  = csn_w & ~csn_q;

    // Shift MOSI on each sampled rising sclk edge while selected.
    // The bit count stops at sixteen, so a longer frame keeps its last
    // sixteen bits; chip select high clears the count for the next frame.
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sclk_q  <= 1'b0;
            csn_q   <= 1'b1;
            shift_q <= 16'h0000;
            count_q <= 5'h0_0;
        end else if (enable_i) begin
            sclk_q <= sclk_w;
            csn_q  <= csn_w;
            if (csn_w) begin
                count_q <= 5'h0_0;
            end else if (sclk_rise_w) begin
                shift_q <= {shift_q[14:0], mosi_w};
                if (count_q != `LINCFG_FRAME_BITS) begin
                    count_q <= count_q + 5'h0_1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame decode.

    // A frame commits at the edge where the synchronised chip select is seen
    // rising, about three clock cycles after the pin itself rises.

    // Command prefix, register address and data byte of the shifted frame.
    // The bit between address and data is not checked.
    wire [1:0] cmd_w  = shift_q[`LINCFG_CMD_MSB:`LINCFG_CMD_LSB];
    wire [4:0] addr_w = shift_q[`LINCFG_ADDR_MSB:`LINCFG_ADDR_LSB];
    wire [7:0] data_w = shift_q[`LINCFG_DATA_MSB:`LINCFG_DATA_LSB];

    wire frame_ok_w = csn_rise_w && (count_q == `LINCFG_FRAME_BITS) &&
                      (cmd_w == `LINCFG_CMD_WRITE);
    // Address match.
    // One write strobe per register address.
    wire [1:0] wr_w;
    assign wr_w[0] = frame_ok_w && (addr_w == `LINCFG_ADDR_CH1);
    assign wr_w[1] = frame_ok_w && (addr_w == `LINCFG_ADDR_CH2);

    ////////////////////////////////////////////////////////////////////////
    // Channel registers and decoded controls.

    wire [7:0] wdata_w = data_w & `LINCFG_WR_MASK;

    // One stored byte per channel, addressed by the channel index.
    reg  [7:0] cfg_q [0:1];

    // Per channel: refusal of transmit/receive, the stored byte and its decode.
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
            wire [1:0] req_mode_w = wdata_w[`LINCFG_MODE_MSB:`LINCFG_MODE_LSB];
            wire [1:0] cur_mode_w = cfg_q[ch][`LINCFG_MODE_MSB:`LINCFG_MODE_LSB];
            wire [1:0] cur_slew_w = cfg_q[ch][`LINCFG_SLEW_MSB:`LINCFG_SLEW_LSB];
            // Refuse transmit/receive on dominant.
            // The transmit level is the synchronised one at the commit edge; a
            // refused request leaves the channel disabled, the other bits still land.
            wire       refuse_w = (req_mode_w == `LINCFG_MODE_TXRX) && !txd_w[ch];
            wire [1:0] mode_w = refuse_w ? `LINCFG_MODE_OFF : req_mode_w;

            always @(posedge clock_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    cfg_q[ch] <= `LINCFG_RESET;
                end else if (enable_i && wr_w[ch]) begin
                    cfg_q[ch] <= {mode_w, wdata_w[`LINCFG_SLEW_MSB:`LINCFG_LOWSUP_BIT]};
                end
            end

            // Decoded controls registered from the stored configuration, one
            // cycle after a write, so that every output comes from a flip-flop.
            always @(posedge clock_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    txrx_enable_o[ch]        <= 1'b0;
                    wake_enable_o[ch]        <= 1'b0;
                    fast_slew_o[ch]          <= 1'b0;
                    slew_10k_o[ch]           <= 1'b0;
                    termination_enable_o[ch] <= 1'b0;
                    force_recessive_o[ch]    <= 1'b0;
                end else if (enable_i) begin
                    // Mode decode.
                    // Transmit/receive also waits for the regulator to be on.
                    txrx_enable_o[ch] <= (cur_mode_w == `LINCFG_MODE_TXRX) && regon_w;
                    wake_enable_o[ch] <= (cur_mode_w == `LINCFG_MODE_WAKE);
                    // Slew decode.
                    // Either code with bit 5 set selects the fast class.
                    fast_slew_o[ch]   <= cfg_q[ch][`LINCFG_SLEW_MSB];
                    slew_10k_o[ch]    <= (cur_slew_w == `LINCFG_SLEW_10K);
                    termination_enable_o[ch] <= cfg_q[ch][`LINCFG_TERM_BIT];
                    // Low supply behaviour; regulator off stops the channel.
                    // With the extension bit set only the regulator turning off silences it.
                    force_recessive_o[ch] <= !regon_w ||
                                             (suplow_w && !cfg_q[ch][`LINCFG_LOWSUP_BIT]);
                end
            end
        end
    endgenerate

    // Register contents straight from the channel flip-flops.
    always @* begin
        lin_channel_one_config_o = cfg_q[0];
        lin_channel_two_config_o = cfg_q[1];
    end

endmodule

// >>> dv/lincfg_host.sv
/* SPI master model that writes the channel registers.
   Assumes mode 0, MSB first, called on a falling edge of the bench clock. */
`timescale 1ns/1ps
module lincfg_host (
    // SPI master pins.
    output logic sclk_o = 1'b0,
    output logic csn_o  = 1'b1,
    output logic mosi_o = 1'b0
);
    task automatic send(input logic [15:0] word);
        csn_o = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi_o = word[i];
            #80 sclk_o = 1'b1;
            #80 sclk_o = 1'b0;
        end
        // The data line no longer shows the last bit once released.
        mosi_o = ~word[0];
        #80 csn_o = 1'b1;
    endtask
endmodule

// >>> dv/lincfg_chk.sv
/* Checker on the ports of the configuration register block.
   Assumes no frame reaches the block while enable_i is low. */
`timescale 1ns/1ps
module lincfg_chk (
    // Clock, reset and inputs.
    input wire       clock_i, resetn_i, spi_csn_i, txd_ch1_i,
    input wire       transceiver_regulator_on_i,
    // Outputs watched.
    input wire [7:0] lin_channel_one_config_o, lin_channel_two_config_o,
    input wire [1:0] wake_enable_o, fast_slew_o, slew_10k_o,
    input wire [1:0] termination_enable_o, force_recessive_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // Regulator held on while the supply extension bit is set.
    sequence reg_held;
        transceiver_regulator_on_i [*6];
    endsequence
    sequence ext_set;
        lin_channel_one_config_o[0] [*2];
    endsequence
    chk_reserved_zero: assert property (lin_channel_one_config_o[3] == 1'b0 &&
        lin_channel_one_config_o[1] == 1'b0 && (lin_channel_two_config_o & 8'h0A) == 8'h00)
        else $error("reserved bit set");
    chk_reset_clear: assert property (disable iff (1'b0) !resetn_i |->
        lin_channel_one_config_o == 8'h00 && lin_channel_two_config_o == 8'h00)
        else $error("register not cleared in reset");
    chk_commit_csn: assert property ($changed(lin_channel_one_config_o) |->
        $past(spi_csn_i)) else $error("register changed inside a frame");
    chk_wake_decode: assert property (wake_enable_o[0] ==
        ($past(lin_channel_one_config_o[7:6]) == 2'h2)) else $error("wake decode wrong");
    chk_slew_decode: assert property ({fast_slew_o[0], slew_10k_o[0]} ==
        {$past(lin_channel_one_config_o[5]), $past(lin_channel_one_config_o[5:4]) == 2'h1})
        else $error("slew decode wrong");
    chk_term_decode: assert property (termination_enable_o ==
        {$past(lin_channel_two_config_o[2]), $past(lin_channel_one_config_o[2])})
        else $error("termination decode wrong");
    chk_ext_keep: assert property (reg_held ##0 ext_set |-> !force_recessive_o[0])
        else $error("channel forced recessive with extension set");
    chk_txrx_refuse: assert property ((!txd_ch1_i [*6]) ##0
        $changed(lin_channel_one_config_o) |-> lin_channel_one_config_o[7:6] != 2'h3)
        else $error("transmit mode taken while transmit input dominant");
endmodule
bind lincfg_top lincfg_chk u_chk (.clock_i(clock_i), .resetn_i(resetn_i),
    .spi_csn_i(spi_csn_i), .txd_ch1_i(txd_ch1_i),
    .transceiver_regulator_on_i(transceiver_regulator_on_i),
    .lin_channel_one_config_o(lin_channel_one_config_o),
    .lin_channel_two_config_o(lin_channel_two_config_o), .wake_enable_o(wake_enable_o),
    .fast_slew_o(fast_slew_o), .slew_10k_o(slew_10k_o),
    .termination_enable_o(termination_enable_o), .force_recessive_o(force_recessive_o));

// >>> dv/lincfg_top_tb_top.sv
/* Self-checking bench for the channel configuration registers.
   Assumes the host model drives frames and the checker is bound. */
`timescale 1ns/1ps
module lincfg_top_tb_top;
    logic       clock_i = 1'b1, resetn_i = 1'b1, txd_ch1_i = 1'b1, txd_ch2_i = 1'b1;
    logic       supply_low_i = 1'b1, reg_on = 1'b0, enable = 1'b1;
    wire        sclk, csn, mosi;
    wire  [7:0] cfg1, cfg2;
    wire  [1:0] txrx, wake, fast, s10k, term, frc;
    int         num_errors = 0, comparisons = 0, cycles = 0;
    always #5 clock_i = ~clock_i;
    lincfg_host host (.sclk_o(sclk), .csn_o(csn), .mosi_o(mosi));
    lincfg_top dut (.clock_i(clock_i), .resetn_i(resetn_i), .enable_i(enable),
        .spi_sclk_i(sclk), .spi_csn_i(csn), .spi_mosi_i(mosi), .txd_ch1_i(txd_ch1_i),
        .txd_ch2_i(txd_ch2_i), .supply_low_i(supply_low_i), .transceiver_regulator_on_i(reg_on),
        .lin_channel_one_config_o(cfg1), .lin_channel_two_config_o(cfg2),
        .txrx_enable_o(txrx), .wake_enable_o(wake), .fast_slew_o(fast), .slew_10k_o(s10k),
        .termination_enable_o(term), .force_recessive_o(frc));
    task automatic wrap_up();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // A hung run counts as a mismatch.
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            wrap_up();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Expected controls: txrx, wake, fast, 10k, termination, forced recessive.
    function automatic logic [5:0] dec(input logic [7:0] c, input logic r, input logic s);
        dec = {c[7:6] == 2'h3 && r, c[7:6] == 2'h2, c[5], c[5:4] == 2'h1, c[2],
               !r || (s && !c[0])};
    endfunction
    task automatic wr(input logic [1:0] cmd, input logic [4:0] adr, input logic [7:0] d);
        host.send({cmd, adr, 1'b0, d});
        repeat (8) @(negedge clock_i);
    endtask
    task automatic cmp(input logic [7:0] e1, input logic [7:0] e2);
        check(cfg1, e1);
        check(cfg2, e2);
        check({2'h0, txrx[0], wake[0], fast[0], s10k[0], term[0], frc[0]},
              {2'h0, dec(e1, reg_on, supply_low_i)});
        check({2'h0, txrx[1], wake[1], fast[1], s10k[1], term[1], frc[1]},
              {2'h0, dec(e2, reg_on, supply_low_i)});
    endtask
    initial begin
        // Assert reset on the first falling edge, before any rising edge.
        @(negedge clock_i);
        resetn_i = 1'b0;
        repeat (12) @(negedge clock_i);
        resetn_i = 1'b1;
        // Regulator on before the channels are used.
        reg_on = 1'b1;
        repeat (6) @(negedge clock_i);
        cmp(8'h00, 8'h00);
        // Every mode and slew code on both channels, reserved bits written as ones.
        for (int i = 0; i < 4; i++) begin
            wr(2'h1, 5'h13, {i[1:0], i[1:0], 4'hF});
            wr(2'h1, 5'h14, {i[1:0], ~i[1:0], 4'hA});
            cmp({i[1:0], i[1:0], 4'h5}, {i[1:0], ~i[1:0], 4'h0});
        end
        wr(2'h3, 5'h13, 8'h00);
        wr(2'h1, 5'h15, 8'h00);
        cmp(8'hF5, 8'hC0);
        txd_ch1_i = 1'b0;
        wr(2'h1, 5'h13, 8'hCD);
        cmp(8'h05, 8'hC0);
        txd_ch2_i = 1'b0;
        wr(2'h1, 5'h14, 8'hC4);
        cmp(8'h05, 8'h04);
        // Clock enable low: a whole frame is lost and nothing moves.
        txd_ch1_i = 1'b1;
        txd_ch2_i = 1'b1;
        enable = 1'b0;
        wr(2'h1, 5'h13, 8'h80);
        enable = 1'b1;
        repeat (6) @(negedge clock_i);
        cmp(8'h05, 8'h04);
        supply_low_i = 1'b0;
        reg_on = 1'b0;
        repeat (6) @(negedge clock_i);
        cmp(8'h05, 8'h04);
        reg_on = 1'b1;
        resetn_i = 1'b0;
        repeat (2) @(negedge clock_i);
        cmp(8'h00, 8'h00);
        resetn_i = 1'b1;
        // A write after the second release lands normally.
        repeat (3) @(negedge clock_i);
        wr(2'h1, 5'h14, 8'hD5);
        cmp(8'h00, 8'hD5);
        wrap_up();
    end
endmodule
